// File: src/oscsw_pkg.sv
// constants, field layout and source codes for the oscillator switch controller
// How it works
// - interrupt clears ratio enable when recover set
// - ratio field selects cpu ratio 1:2^n
// - ratio enable clear forces cpu ratio 1:1
// - fast rc postscaler divides, reset code 001
// - six-bit signed trim offset, zero is centre
// - unimplemented bits always read as zero
// - switching and monitor only when config is 00
// - switching off: next select ignored, current follows config
// - switching off: switch request held at zero
// - high byte writes need 78h then 9Ah
// - low byte writes need 46h then 57h
// - equal sources: clear request, abort switch
// - valid switch start clears lock and fail flag
// - start new oscillator, await start-up or lock
// - count ten new clock cycles before changeover
// - changeover clears request, copies next to current
// - old source stops except kept low-power/secondary
// - primary submode fixed, runtime switch cannot change
// - secondary oscillator starts on module request
// - secondary pins oscillator for 11/01, digital 00
// - source select code assignments
package oscsw_pkg;
   // register byte offsets
   localparam logic [3:0]  OSC_CONTROL_REG_OFS     = 4'h0;
   localparam logic [3:0]  CLOCK_DIVIDER_CTRL_OFS  = 4'h4;
   localparam logic [3:0]  FAST_RC_TRIM_CTRL_OFS   = 4'h8;
   localparam logic [3:0]  CLOCK_CONFIG_OFS        = 4'hc;
   // osc_control_reg fields
   localparam int          CUR_SRC_LSB             = 12;
   localparam int          NXT_SRC_LSB             = 8;
   localparam int          LOCK_BIT                = 5;
   localparam int          FAIL_BIT                = 3;
   localparam int          PRIM_SLEEP_BIT          = 2;
   localparam int          SECONDARY_OSC_EN_BIT             = 1;
   localparam int          SWITCH_REQ_BIT          = 0;
   // clock_divider_control fields
   localparam int          RECOVER_BIT             = 15;
   localparam int          SLOW_RATIO_LSB          = 12;
   localparam int          RATIO_EN_BIT            = 11;
   localparam int          POSTSCALE_LSB           = 8;
   localparam logic [2:0]  POSTSCALE_RST           = 3'h1;
   localparam logic [2:0]  POSTSCALE_MAX_CODE      = 3'h7;
   localparam logic [3:0]  POSTSCALE_MAX_SHIFT     = 4'h8;
   // configuration register fields
   localparam int          CFG_MON_LSB             = 0;
   localparam int          CFG_INIT_LSB            = 2;
   localparam int          CFG_SUBMODE_LSB         = 5;
   localparam int          CFG_SECONDARY_OSC_MODE_LSB       = 7;
   localparam int          CFG_DONE_BIT            = 9;
   localparam logic [1:0]  MON_CFG_RST             = 2'h3;
   localparam logic [1:0]  MON_CFG_SWITCH_ON       = 2'h0;
   localparam logic [2:0]  INIT_SRC_RST            = 3'h7;
   localparam logic [1:0]  SUBMODE_RST             = 2'h3;
   localparam logic [1:0]  SUBMODE_EXT_CLOCK       = 2'h0;
   localparam logic [1:0]  SECONDARY_OSC_MODE_RST           = 2'h3;
   localparam logic [1:0]  SECONDARY_OSC_MODE_LP            = 2'h1;
   localparam logic [1:0]  SECONDARY_OSC_MODE_OSC           = 2'h3;
   // unlock keys
   localparam logic [7:0]  HI_KEY_1                = 8'h78;
   localparam logic [7:0]  HI_KEY_2                = 8'h9a;
   localparam logic [7:0]  LO_KEY_1                = 8'h46;
   localparam logic [7:0]  LO_KEY_2                = 8'h57;
   // new clock cycles counted before changeover
   localparam logic [3:0]  NEW_CLK_CYCLES          = 4'ha;
   // source select codes
   typedef enum logic [2:0] {
      OSCSW_SRC_FRC      = 3'h0,
      OSCSW_SRC_FRC_PLL  = 3'h1,
      OSCSW_SRC_PRIM     = 3'h2,
      OSCSW_SRC_PRIM_PLL = 3'h3,
      OSCSW_SRC_SEC      = 3'h4,
      OSCSW_SRC_LOW_POWER_INTERNAL_RC     = 3'h5,
      OSCSW_SRC_RSVD     = 3'h6,
      OSCSW_SRC_FRC_DIV  = 3'h7
   } oscsw_src_e;
   // oscillator enable vector positions
   localparam int          EN_FRC                  = 0;
   localparam int          EN_PRIM                 = 1;
   localparam int          EN_SEC                  = 2;
   localparam int          EN_LOW_POWER_INTERNAL_RC                 = 3;
   localparam int          EN_PLL                  = 4;
endpackage

// File: src/oscsw_tick_div.sv
// power-of-two tick divider that changes ratio only at a period boundary
`timescale 1ns/100ps
module oscsw_tick_div #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [3:0]       shift_in,
   output logic                  tick_out
);
   logic [CNT_W-1:0] cnt_ff;
   logic [3:0]       shift_ff;
   logic [CNT_W:0]   lim_wide;
   logic [CNT_W-1:0] lim;

   if (CNT_W < 1 || CNT_W > 15) begin : g_chk
      $error("oscsw_tick_div: CNT_W out of range");
   end

   always_comb begin
      lim_wide = ({{CNT_W{1'b0}}, 1'b1} << shift_ff) - {{CNT_W{1'b0}}, 1'b1};
      lim      = lim_wide[CNT_W-1:0];
   end

   // new ratio taken only when the running period wraps
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_ff   <= '0;
         shift_ff <= 4'h0;
         tick_out <= 1'b0;
      end else if (cnt_ff == lim) begin
         cnt_ff   <= '0;
         shift_ff <= shift_in;
         tick_out <= 1'b1;
      end else begin
         cnt_ff   <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         tick_out <= 1'b0;
      end
   end
endmodule

// File: src/oscsw_top.sv
// oscillator switch controller with divider, postscaler, trim and avalon slave
`timescale 1ns/100ps
module oscsw_top
   import oscsw_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic [3:0]  osc_clk_in,
   input  wire logic        prim_startup_done_in,
   input  wire logic        pll_lock_in,
   input  wire logic        irq_in,
   input  wire logic        secondary_osc_module_req_in,
   input  wire logic        wdt_enable_in,
   input  wire logic        clock_fail_in,
   output logic      [4:0]  osc_enable_out,
   output logic      [2:0]  current_source_out,
   output logic      [5:0]  fast_rc_trim_out,
   output logic             cpu_tick_out,
   output logic             frc_post_tick_out,
   output logic             fail_safe_en_out,
   output logic             secondary_osc_pins_osc_mode_out,
   output logic             switch_busy_out
);
   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_COMPARE = 6'h02,
      ST_START   = 6'h04,
      ST_WAIT    = 6'h08,
      ST_COUNT   = 6'h10,
      ST_CHANGE  = 6'h20
   } oscsw_state_e;

   if (DIV_W < 8) begin : g_chk
      $error("oscsw_top: DIV_W must reach divide-by-256");
   end

   oscsw_state_e state_ff;
   oscsw_state_e nxt_state;
   logic [2:0]   cur_src_ff;
   logic [2:0]   nxt_src_ff;
   logic [2:0]   tgt_ff;
   logic         req_ff;
   logic         lock_ff;
   logic         fail_ff;
   logic         prim_sleep_ff;
   logic         secondary_osc_en_ff;
   logic         roi_ff;
   logic [2:0]   doze_ff;
   logic         cpu_ratio_enable_ff;
   logic [2:0]   fast_rc_postscale_ff;
   logic [5:0]   trim_ff;
   logic [1:0]   mon_cfg_ff;
   logic [2:0]   init_cfg_ff;
   logic [1:0]   sub_cfg_ff;
   logic [1:0]   secondary_osc_cfg_ff;
   logic         cfg_done_ff;
   logic [1:0]   hi_stage_ff;
   logic [1:0]   lo_stage_ff;
   logic [3:0]   cnt_ff;
   logic [3:0]   clk_s1_ff;
   logic [3:0]   clk_s2_ff;
   logic [3:0]   clk_s3_ff;
   logic [1:0]   rdy_s1_ff;
   logic [1:0]   rdy_s2_ff;
   logic         wait_ff;
   logic [31:0]  rdata_ff;
   logic [4:0]   osc_en_ff;

   logic         switch_en;
   logic         fsm_en;
   logic         wr_fire;
   logic         osc_sel;
   logic         hi_ok;
   logic         lo_ok;
   logic [7:0]   hi_byte;
   logic [7:0]   lo_byte;
   logic         need_ost;
   logic         need_pll;
   logic         src_ready;
   logic [1:0]   tgt_clk;
   logic         tgt_edge;
   logic [3:0]   cpu_shift;
   logic [3:0]   post_shift;
   logic [4:0]   want_en;

   function automatic logic [4:0] src_need(input logic [2:0] s);
      logic [4:0] e;
      e = 5'h00;
      unique case (s)
         OSCSW_SRC_FRC, OSCSW_SRC_FRC_DIV: e[EN_FRC] = 1'b1;
         OSCSW_SRC_FRC_PLL: begin
            e[EN_FRC] = 1'b1;
            e[EN_PLL] = 1'b1;
         end
         OSCSW_SRC_PRIM:    e[EN_PRIM] = 1'b1;
         OSCSW_SRC_PRIM_PLL: begin
            e[EN_PRIM] = 1'b1;
            e[EN_PLL]  = 1'b1;
         end
         OSCSW_SRC_SEC:     e[EN_SEC] = 1'b1;
         OSCSW_SRC_LOW_POWER_INTERNAL_RC:    e[EN_LOW_POWER_INTERNAL_RC] = 1'b1;
         default:           e = 5'h00;
      endcase
      return e;
   endfunction

   assign switch_en = (mon_cfg_ff == MON_CFG_SWITCH_ON);
   assign fsm_en    = (mon_cfg_ff == MON_CFG_SWITCH_ON);
   assign wr_fire   = avs_write_in && !wait_ff;
   assign osc_sel   = (avs_address_in == OSC_CONTROL_REG_OFS);
   assign hi_byte   = avs_writedata_in[15:8];
   assign lo_byte   = avs_writedata_in[7:0];
   assign hi_ok     = wr_fire && osc_sel && avs_byteenable_in[1] && (hi_stage_ff == 2'h2);
   assign lo_ok     = wr_fire && osc_sel && avs_byteenable_in[0] && (lo_stage_ff == 2'h2);

   // avalon slave: waitrequest drops one cycle after a request arrives
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !((avs_read_in || avs_write_in) && wait_ff);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_in && wait_ff) begin
         unique case (avs_address_in)
            OSC_CONTROL_REG_OFS:
               rdata_ff <= {16'h0000, 1'b0, cur_src_ff, 1'b0, nxt_src_ff, 2'b00, lock_ff, 1'b0,
                            fail_ff, prim_sleep_ff, secondary_osc_en_ff, req_ff};
            CLOCK_DIVIDER_CTRL_OFS:
               rdata_ff <= {16'h0000, roi_ff, doze_ff, cpu_ratio_enable_ff, fast_rc_postscale_ff, 8'h00};
            FAST_RC_TRIM_CTRL_OFS:
               rdata_ff <= {26'h0000000, trim_ff};
            CLOCK_CONFIG_OFS:
               rdata_ff <= {22'h000000, cfg_done_ff, secondary_osc_cfg_ff, sub_cfg_ff, init_cfg_ff, mon_cfg_ff};
            default:
               rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // unlock sequences, one per byte; any other write breaks the sequence
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hi_stage_ff <= 2'h0;
      end else if (wr_fire) begin
         if (osc_sel && avs_byteenable_in[1]) begin
            if (hi_stage_ff == 2'h1 && hi_byte == HI_KEY_2) begin
               hi_stage_ff <= 2'h2;
            end else if (hi_stage_ff != 2'h2 && hi_byte == HI_KEY_1) begin
               hi_stage_ff <= 2'h1;
            end else begin
               hi_stage_ff <= 2'h0;
            end
         end else begin
            hi_stage_ff <= 2'h0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lo_stage_ff <= 2'h0;
      end else if (wr_fire) begin
         if (osc_sel && avs_byteenable_in[0]) begin
            if (lo_stage_ff == 2'h1 && lo_byte == LO_KEY_2) begin
               lo_stage_ff <= 2'h2;
            end else if (lo_stage_ff != 2'h2 && lo_byte == LO_KEY_1) begin
               lo_stage_ff <= 2'h1;
            end else begin
               lo_stage_ff <= 2'h0;
            end
         end else begin
            lo_stage_ff <= 2'h0;
         end
      end
   end

   // configuration: written once after reset, then frozen
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mon_cfg_ff  <= MON_CFG_RST;
         init_cfg_ff <= INIT_SRC_RST;
         sub_cfg_ff  <= SUBMODE_RST;
         secondary_osc_cfg_ff <= SECONDARY_OSC_MODE_RST;
         cfg_done_ff <= 1'b0;
      end else if (wr_fire && avs_address_in == CLOCK_CONFIG_OFS && avs_byteenable_in[1:0] == 2'b11
                   && !cfg_done_ff) begin
         mon_cfg_ff  <= avs_writedata_in[CFG_MON_LSB +: 2];
         init_cfg_ff <= avs_writedata_in[CFG_INIT_LSB +: 3];
         sub_cfg_ff  <= avs_writedata_in[CFG_SUBMODE_LSB +: 2];
         secondary_osc_cfg_ff <= avs_writedata_in[CFG_SECONDARY_OSC_MODE_LSB +: 2];
         cfg_done_ff <= 1'b1;
      end
   end

   // next source select and plain low-byte control bits
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         nxt_src_ff <= INIT_SRC_RST;
      end else if (!cfg_done_ff || !switch_en) begin
         nxt_src_ff <= init_cfg_ff;
      end else if (hi_ok && state_ff == ST_IDLE) begin
         nxt_src_ff <= hi_byte[2:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prim_sleep_ff <= 1'b0;
         secondary_osc_en_ff    <= 1'b0;
      end else if (lo_ok) begin
         prim_sleep_ff <= lo_byte[PRIM_SLEEP_BIT];
         secondary_osc_en_ff    <= lo_byte[SECONDARY_OSC_EN_BIT];
      end
   end

   // switch request: set by unlocked write, cleared by hardware
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_ff <= 1'b0;
      end else if (!switch_en) begin
         req_ff <= 1'b0;
      end else if (lo_ok && lo_byte[SWITCH_REQ_BIT] && state_ff == ST_IDLE) begin
         req_ff <= 1'b1;
      end else if (state_ff == ST_COMPARE && (tgt_ff == cur_src_ff || tgt_ff == OSCSW_SRC_RSVD)) begin
         req_ff <= 1'b0;
      end else if (state_ff == ST_CHANGE) begin
         req_ff <= 1'b0;
      end
   end

   // clock fail flag: monitor sets, switch start or software clears, set wins
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fail_ff <= 1'b0;
      end else if (clock_fail_in && fsm_en) begin
         fail_ff <= 1'b1;
      end else if (state_ff == ST_START) begin
         fail_ff <= 1'b0;
      end else if (lo_ok && !lo_byte[FAIL_BIT]) begin
         fail_ff <= 1'b0;
      end
   end

   // pll lock status
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lock_ff <= 1'b0;
      end else if (state_ff == ST_START) begin
         lock_ff <= 1'b0;
      end else begin
         lock_ff <= rdy_s2_ff[1] && osc_en_ff[EN_PLL];
      end
   end

   // synchronisers for oscillator clocks and readiness levels
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clk_s1_ff <= 4'h0;
         clk_s2_ff <= 4'h0;
         clk_s3_ff <= 4'h0;
         rdy_s1_ff <= 2'h0;
         rdy_s2_ff <= 2'h0;
      end else begin
         clk_s1_ff <= osc_clk_in;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
         rdy_s1_ff <= {pll_lock_in, prim_startup_done_in};
         rdy_s2_ff <= rdy_s1_ff;
      end
   end

   always_comb begin
      unique case (tgt_ff)
         OSCSW_SRC_PRIM, OSCSW_SRC_PRIM_PLL: tgt_clk = 2'h1;
         OSCSW_SRC_SEC:                      tgt_clk = 2'h2;
         OSCSW_SRC_LOW_POWER_INTERNAL_RC:                     tgt_clk = 2'h3;
         default:                            tgt_clk = 2'h0;
      endcase
   end

   assign tgt_edge  = clk_s2_ff[tgt_clk] && !clk_s3_ff[tgt_clk];
   assign need_ost  = (tgt_ff == OSCSW_SRC_PRIM || tgt_ff == OSCSW_SRC_PRIM_PLL)
                      && sub_cfg_ff != SUBMODE_EXT_CLOCK;
   assign need_pll  = (tgt_ff == OSCSW_SRC_FRC_PLL || tgt_ff == OSCSW_SRC_PRIM_PLL);
   assign src_ready = (!need_ost || rdy_s2_ff[0]) && (!need_pll || rdy_s2_ff[1]);

   // switch sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:    if (req_ff) nxt_state = ST_COMPARE;
         ST_COMPARE: begin
            if (tgt_ff == cur_src_ff || tgt_ff == OSCSW_SRC_RSVD) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_START;
            end
         end
         ST_START:   nxt_state = ST_WAIT;
         ST_WAIT:    if (src_ready) nxt_state = ST_COUNT;
         ST_COUNT:   if (cnt_ff == NEW_CLK_CYCLES) nxt_state = ST_CHANGE;
         ST_CHANGE:  nxt_state = ST_IDLE;
         default:    nxt_state = ST_IDLE;
      endcase
      if (!switch_en) begin
         nxt_state = ST_IDLE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tgt_ff <= INIT_SRC_RST;
      end else if (state_ff == ST_IDLE) begin
         tgt_ff <= nxt_src_ff;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_ff <= 4'h0;
      end else if (state_ff != ST_COUNT) begin
         cnt_ff <= 4'h0;
      end else if (tgt_edge) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end

   // current source: follows config when switching is off
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cur_src_ff <= INIT_SRC_RST;
      end else if (!switch_en || !cfg_done_ff) begin
         cur_src_ff <= init_cfg_ff;
      end else if (state_ff == ST_CHANGE) begin
         cur_src_ff <= tgt_ff;
      end
   end

   // oscillator enables: current source, pending target and kept sources
   always_comb begin
      want_en = src_need(cur_src_ff);
      if (state_ff == ST_START || state_ff == ST_WAIT || state_ff == ST_COUNT || state_ff == ST_CHANGE) begin
         want_en = want_en | src_need(tgt_ff);
      end
      if (wdt_enable_in || fsm_en) begin
         want_en[EN_LOW_POWER_INTERNAL_RC] = 1'b1;
      end
      if ((secondary_osc_en_ff || secondary_osc_module_req_in)
          && (secondary_osc_cfg_ff == SECONDARY_OSC_MODE_OSC || secondary_osc_cfg_ff == SECONDARY_OSC_MODE_LP)) begin
         want_en[EN_SEC] = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         osc_en_ff <= 5'h00;
      end else begin
         osc_en_ff <= want_en;
      end
   end

   // clock divider control register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         roi_ff   <= 1'b0;
         doze_ff  <= 3'h0;
         fast_rc_postscale_ff <= POSTSCALE_RST;
      end else if (wr_fire && avs_address_in == CLOCK_DIVIDER_CTRL_OFS && avs_byteenable_in[1]) begin
         roi_ff   <= avs_writedata_in[RECOVER_BIT];
         doze_ff  <= avs_writedata_in[SLOW_RATIO_LSB +: 3];
         fast_rc_postscale_ff <= avs_writedata_in[POSTSCALE_LSB +: 3];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cpu_ratio_enable_ff <= 1'b0;
      end else if (irq_in && roi_ff) begin
         cpu_ratio_enable_ff <= 1'b0;
      end else if (wr_fire && avs_address_in == CLOCK_DIVIDER_CTRL_OFS && avs_byteenable_in[1]) begin
         cpu_ratio_enable_ff <= avs_writedata_in[RATIO_EN_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         trim_ff <= 6'h00;
      end else if (wr_fire && avs_address_in == FAST_RC_TRIM_CTRL_OFS && avs_byteenable_in[0]) begin
         trim_ff <= avs_writedata_in[5:0];
      end
   end

   assign cpu_shift  = cpu_ratio_enable_ff ? {1'b0, doze_ff} : 4'h0;
   assign post_shift = (fast_rc_postscale_ff == POSTSCALE_MAX_CODE) ? POSTSCALE_MAX_SHIFT : {1'b0, fast_rc_postscale_ff};

   oscsw_tick_div #(.CNT_W(DIV_W)) u_cpu_div (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .shift_in (cpu_shift),
      .tick_out (cpu_tick_out)
   );

   oscsw_tick_div #(.CNT_W(DIV_W)) u_post_div (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .shift_in (post_shift),
      .tick_out (frc_post_tick_out)
   );

   // registered status outputs
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         current_source_out     <= INIT_SRC_RST;
         fast_rc_trim_out       <= 6'h00;
         fail_safe_en_out       <= 1'b0;
         secondary_osc_pins_osc_mode_out <= 1'b1;
         switch_busy_out        <= 1'b0;
      end else begin
         current_source_out     <= cur_src_ff;
         fast_rc_trim_out       <= trim_ff;
         fail_safe_en_out       <= fsm_en;
         secondary_osc_pins_osc_mode_out <= (secondary_osc_cfg_ff == SECONDARY_OSC_MODE_OSC || secondary_osc_cfg_ff == SECONDARY_OSC_MODE_LP);
         switch_busy_out        <= (state_ff != ST_IDLE);
      end
   end

   assign avs_readdata_out    = rdata_ff;
   assign avs_waitrequest_out = wait_ff;
   assign osc_enable_out      = osc_en_ff;
endmodule

// File: verification/oscsw_top_chk.sv
// bus, switch sequence and trim assertions for the oscillator switch controller
`timescale 1ns/100ps
module oscsw_top_chk (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic [4:0]  osc_enable_out,
   input wire logic [2:0]  current_source_out,
   input wire logic [5:0]  fast_rc_trim_out,
   input wire logic        switch_busy_out
);
   logic [7:0] run_ff;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // busy cycles since the last register write
   always_ff @(posedge clk_in) begin
      if (rst_in || avs_write_in) begin
         run_ff <= 8'h00;
      end else if (switch_busy_out && run_ff != 8'hff) begin
         run_ff <= run_ff + 8'h01;
      end
   end
   chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("no answer one cycle after request");
   chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");
   chk_idle_wait: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
      else $error("waitrequest low without request");
   chk_rd_upper: assert property (avs_readdata_out[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   chk_trim_cause: assert property ($changed(fast_rc_trim_out) |-> $past(avs_write_in, 2))
      else $error("trim output changed without write");
   chk_busy_cause: assert property ($rose(switch_busy_out) |->
      $past(avs_write_in, 2) || $past(avs_write_in, 3) || $past(avs_write_in, 4))
      else $error("switch started without write");
   chk_pll_cause: assert property ($rose(osc_enable_out[4]) |-> switch_busy_out || $past(switch_busy_out))
      else $error("pll enabled outside switch");
   chk_switch_len: assert property ($changed(current_source_out) &&
      (switch_busy_out || $past(switch_busy_out) || $past(switch_busy_out, 2)) |-> run_ff >= 8'h0c)
      else $error("changeover too early");
endmodule
bind oscsw_top oscsw_top_chk i_chk (.*);

// File: verification/testbench.sv
// self-checking testbench for the oscillator switch controller
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   import oscsw_pkg::*;
   logic        clk_in = 1'h0, rst_in = 1'h1, avs_read_in = 1'h0, avs_write_in = 1'h0;
   logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'h0, osc_clk_in = 4'h0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, v;
   logic        prim_startup_done_in = 1'h0, pll_lock_in = 1'h0, irq_in = 1'h0;
   logic        secondary_osc_module_req_in = 1'h0, wdt_enable_in = 1'h0, clock_fail_in = 1'h0;
   logic        avs_waitrequest_out, cpu_tick_out, frc_post_tick_out, fail_safe_en_out;
   logic        secondary_osc_pins_osc_mode_out, switch_busy_out;
   logic [4:0]  osc_enable_out;
   logic [2:0]  current_source_out;
   logic [5:0]  fast_rc_trim_out;
   logic [15:0] q;
   int          err_total = 0, checks = 0, p;
   oscsw_top i_dut (.*);
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) osc_clk_in <= osc_clk_in + 4'h1;
   function automatic int post_per(input int c);
      return (c == 7) ? 256 : (1 << c);
   endfunction
   function automatic logic [15:0] roi_exp(input logic [15:0] d);
      return d[15] ? (d & 16'hf7ff) : d;
   endfunction
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      avs_byteenable_in <= be;
      avs_read_in <= ~w;
      avs_write_in <= w;
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'h0);
      q = avs_readdata_out[15:0];
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
      @(posedge clk_in);
   endtask
   task automatic per(input logic s, output int t);
      repeat (3) begin
         t = 0;
         do begin
            @(posedge clk_in);
            t++;
         end while ((s ? frc_post_tick_out : cpu_tick_out) !== 1'h1 && t < 600);
      end
   endtask
   task automatic sw(input logic [2:0] s);
      logic [15:0] sq [6];
      sq = '{16'h7800, 16'h9a00, {5'h00, s, 8'h00}, 16'h0046, 16'h0057, 16'h0001};
      foreach (sq[i]) bus(1'h1, 4'h0, sq[i], (i < 3) ? 4'h2 : 4'h1);
   endtask
   task automatic wt;
      int k;
      k = 0;
      repeat (3) @(posedge clk_in);
      while (switch_busy_out !== 1'h0 && k < 3000) begin
         @(posedge clk_in);
         k++;
      end
      `CHK(switch_busy_out, 1'h0)
   endtask
   task automatic give_verdict;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #600000;
      err_total++;
      give_verdict;
   end
   initial begin
      logic [19:0] tab [5];
      logic [15:0] ro [2];
      tab = '{20'h07700, 20'h40100, 20'h80000, 20'hc01ff, 20'h20000};
      ro = '{16'hb800, 16'h3800};
      v = $urandom(77);
      repeat (16) @(posedge clk_in);
      rst_in <= 1'h0;
      @(posedge clk_in);
      foreach (tab[i]) begin
         bus(1'h0, tab[i][19:16], 16'h0000, 4'h3);
         `CHK(q, tab[i][15:0])
      end
      `CHK(osc_enable_out, 5'h01)
      wdt_enable_in <= 1'h1;
      secondary_osc_module_req_in <= 1'h1;
      sw(3'h4);
      bus(1'h0, 4'h0, 16'h0000, 4'h3);
      `CHK(q, 16'h7700)
      `CHK(switch_busy_out, 1'h0)
      `CHK(osc_enable_out, 5'h0d)
      wdt_enable_in <= 1'h0;
      secondary_osc_module_req_in <= 1'h0;
      bus(1'h1, 4'hc, 16'h003c, 4'h3);
      bus(1'h0, 4'hc, 16'h0000, 4'h3);
      `CHK(q, 16'h023c)
      `CHK(fail_safe_en_out, 1'h1)
      `CHK(secondary_osc_pins_osc_mode_out, 1'h0)
      v = $urandom;
      bus(1'h1, 4'h8, v[15:0], 4'h3);
      bus(1'h0, 4'h8, 16'h0000, 4'h3);
      `CHK(q, {10'h000, v[5:0]})
      `CHK(fast_rc_trim_out, v[5:0])
      $display("test reset and config done");
      for (int n = 0; n < 8; n++) begin
         v = $urandom;
         v[15:8] = {1'h0, n[2:0], 1'h1, n[2:0]};
         bus(1'h1, 4'h4, v[15:0], 4'h3);
         bus(1'h0, 4'h4, 16'h0000, 4'h3);
         `CHK(q, {v[15:8], 8'h00})
         per(1'h0, p);
         `CHK(p, 1 << n)
         per(1'h1, p);
         `CHK(p, post_per(n))
      end
      bus(1'h1, 4'h4, 16'h5000, 4'h3);
      per(1'h0, p);
      `CHK(p, 1)
      foreach (ro[i]) begin
         bus(1'h1, 4'h4, ro[i], 4'h3);
         irq_in <= 1'h1;
         @(posedge clk_in);
         irq_in <= 1'h0;
         bus(1'h0, 4'h4, 16'h0000, 4'h3);
         `CHK(q, roi_exp(ro[i]))
      end
      $display("test dividers done");
      prim_startup_done_in <= 1'h1;
      sw(3'h2);
      wt;
      bus(1'h0, 4'h0, 16'h0000, 4'h3);
      `CHK({q[14:8], q[0]}, 8'h44)
      `CHK(current_source_out, 3'h2)
      `CHK(osc_enable_out[EN_FRC], 1'h0)
      bus(1'h1, 4'h0, 16'h0400, 4'h2);
      sw(3'h2);
      wt;
      bus(1'h0, 4'h0, 16'h0000, 4'h3);
      `CHK({q[14:8], q[0]}, 8'h44)
      sw(3'h3);
      repeat (60) @(posedge clk_in);
      `CHK(switch_busy_out, 1'h1)
      bus(1'h0, 4'h0, 16'h0000, 4'h3);
      `CHK({q[5], q[0]}, 2'h1)
      pll_lock_in <= 1'h1;
      wt;
      bus(1'h0, 4'h0, 16'h0000, 4'h3);
      `CHK({q[14:12], q[5], q[0]}, 5'h0e)
      $display("test clock switching done");
      give_verdict;
   end
endmodule
